// >>> logic/bir_pkg.sv
// Package for board interrupt routing: levels, selections, priority classes
package bir_pkg;
    // Number of controller levels over both cascaded controllers
    localparam int NUM_LEVELS = 16;
    // Level numbers on the first and second controller
    localparam int LVL_TICK = 0;
    localparam int LVL_EXP1 = 1;
    localparam int LVL_CASCADE = 2;
    localparam int LVL_SER_TWO = 3;
    localparam int LVL_SER_ONE = 4;
    localparam int LVL_FIVE = 5;
    localparam int LVL_EXP6 = 6;
    localparam int LVL_EXP7 = 7;
    localparam int LVL_EXP8 = 8;
    localparam int LVL_NINE = 9;
    localparam int LVL_TMR1 = 10;
    localparam int LVL_TMR2 = 11;
    localparam int LVL_DMA = 12;
    localparam int LVL_EXP13 = 13;
    localparam int LVL_FOURTEEN = 14;
    localparam int LVL_SPARE = 15;
    // Second controller input two carries timer counter 1 when chosen
    localparam int SEC_INPUT_TWO = 2;
    // Routing selection codes: 0 picks expansion bus, 1 picks alternative
    localparam logic SEL_EXPANSION = 1'h0;
    localparam logic SEL_ALTERNATE = 1'h1;
    localparam logic [2:0] ROUTE_RESET = 3'h0;
    // Bit of the routing selection that belongs to each switched level
    localparam int ROUTE_BIT_FIVE = 0;
    localparam int ROUTE_BIT_NINE = 1;
    localparam int ROUTE_BIT_FOURTEEN = 2;
    // Timer counter 1 use
    localparam logic [1:0] T1_IRQ_LEVEL = 2'h0;
    localparam logic [1:0] T1_SYS_MGMT = 2'h1;
    localparam logic [1:0] T1_DMA_TRIG = 2'h2;
    localparam logic [1:0] T1_SEC_TWO = 2'h3;
    // Real-time clock step in fractions of a second
    localparam int RTC_STEPS_PER_SEC = 64;
    // Event classes, one-hot, highest priority is bit 9
    localparam int NUM_CLASSES = 10;
    typedef enum logic [9:0] {
        EV_NONE = 10'h000,
        EV_MASKABLE = 10'h001,
        EV_NMI = 10'h002,
        EV_ICE_BREAK = 10'h004,
        EV_DEBUG = 10'h008,
        EV_SINGLE_STEP = 10'h010,
        EV_SYS_MGMT = 10'h020,
        EV_DIV_ZERO = 10'h040,
        EV_PAGE_FAULT = 10'h080,
        EV_SEG_VIOL = 10'h100,
        EV_DOUBLE_FAULT = 10'h200
    } bir_event_t;
endpackage : bir_pkg

// >>> logic/bir_sync.sv
// Two-flip-flop synchroniser for a vector of pin levels
`timescale 1ns/100ps
module bir_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Level in and synchronised level out
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } bir_sync_state_t;

    bir_sync_state_t state_reg;
    bir_sync_state_t state_next;

    // First stage is read only by the second stage
    always_comb begin
        state_next = state_reg;
        state_next.stage1 = din;
        state_next.stage2 = state_reg.stage1;
    end

    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign dout = state_reg.stage2;
endmodule : bir_sync

// >>> logic/bir_router.sv
// Board interrupt routing: sources to levels, priority of event classes
`timescale 1ns/100ps
// Functional notes
// - Timer counter 0, the system tick, drives level 0.
// - Level 2 carries the cascade from the second controller only.
// - Serial channel two drives level 3, serial channel one level 4.
// - Expansion lines 1, 6, 7, 8 and 13 pass straight to those levels.
// - Level 5 comes from expansion line 5 or module bus line a.
// - Level 9 comes from expansion line 9 or module bus line b.
// - Level 14 comes from expansion line 14 or the real-time clock.
// - Timer counter 1 may use level 10 and timer counter 2 level 11.
// - Level 12 serves the DMA channel requests.
// - Timer 1 serves system entry, DMA trigger or second input two.
// - The power-fail comparator drives the non-maskable request.
// - A system-management request exists apart from maskable levels.
// - Events rank double fault first down to maskable request last.
// - The real-time clock may raise an interrupt or a wake-up alarm.
module bir_router #(
    parameter int LEVELS = bir_pkg::NUM_LEVELS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // On-chip sources
    input wire logic timer0_out,
    input wire logic timer1_out,
    input wire logic timer2_out,
    input wire logic serial_channel_one_irq,
    input wire logic serial_channel_two_irq,
    input wire logic dma_irq,
    input wire logic second_ctrl_int,
    // Real-time clock events
    input wire logic rtc_irq_en,
    input wire logic rtc_alarm_en,
    input wire logic rtc_tick,
    input wire logic rtc_alarm_match,
    // Pin sources from outside
    input wire logic [LEVELS-1:0] expansion_irq,
    input wire logic module_bus_irq_a,
    input wire logic module_bus_irq_b,
    input wire logic power_fail,
    input wire logic sys_mgmt_req,
    // Static configuration
    input wire logic [2:0] route_sel,
    input wire logic [1:0] timer1_use,
    // Processor-side events
    input wire logic [bir_pkg::NUM_CLASSES-1:0] core_events,
    // Routed outputs
    output logic [LEVELS-1:0] first_ctrl_levels,
    output logic [LEVELS-1:0] second_ctrl_levels,
    output logic nmi,
    output logic system_management_entry,
    output logic dma_trigger,
    output logic rtc_wakeup,
    output bir_pkg::bir_event_t event_grant
);
    typedef struct packed {
        logic [2:0] route;
        logic [1:0] t1_use;
        logic cfg_taken;
        logic [LEVELS-1:0] lvl;
        logic nmi;
        logic smi;
        logic dma_trig;
        logic wake;
        bir_pkg::bir_event_t grant;
    } bir_state_t;

    // Synchroniser width: every expansion line plus module bus a and b,
    // the power-fail level and the external system-management request
    localparam int PIN_W = LEVELS + 4;

    bir_state_t state_reg;
    bir_state_t state_next;
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_sync;
    logic [LEVELS-1:0] exp_s;
    logic mod_a_s;
    logic mod_b_s;
    logic pfail_s;
    logic smreq_s;

    // Picks the expansion line or the alternative source
    function automatic logic pick(input logic sel, input logic exp_line,
                                  input logic alt_line);
        pick = (sel == bir_pkg::SEL_ALTERNATE) ? alt_line : exp_line;
    endfunction : pick

    // Highest set class wins; returns one-hot code
    // Lower class bits are overwritten by higher ones, so the last set
    // bit met in the loop is the one that is granted
    function automatic bir_pkg::bir_event_t rank(
        input logic [bir_pkg::NUM_CLASSES-1:0] ev);
        rank = bir_pkg::EV_NONE;
        for (int i = 0; i < bir_pkg::NUM_CLASSES; i++) begin
            if (ev[i]) begin
                rank = bir_pkg::bir_event_t'(
                    10'(bir_pkg::EV_MASKABLE) << i);
            end
        end
    endfunction : rank

    // Pins from outside pass two flip-flops
    assign pin_raw = {sys_mgmt_req, power_fail, module_bus_irq_b,
                      module_bus_irq_a, expansion_irq};

    bir_sync #(
        .WIDTH(PIN_W)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .din(pin_raw),
        .dout(pin_sync)
    );

    assign exp_s = pin_sync[LEVELS-1:0];
    assign mod_a_s = pin_sync[LEVELS];
    assign mod_b_s = pin_sync[LEVELS+1];
    assign pfail_s = pin_sync[LEVELS+2];
    assign smreq_s = pin_sync[LEVELS+3];

    // Next-state logic for routing and priority
    always_comb begin
        logic [bir_pkg::NUM_CLASSES-1:0] ev;
        logic rtc_ev;
        ev = '0;
        rtc_ev = 1'b0;
        state_next = state_reg;
        // Capture static choices once after reset release
        // Jumper-like choices are read once; later changes wait for the
        // next reset, so a level never flips source in mid-request
        if (!state_reg.cfg_taken) begin
            state_next.route = route_sel;
            state_next.t1_use = timer1_use;
            state_next.cfg_taken = 1'b1;
        end
        state_next.lvl = '0;
        state_next.lvl[bir_pkg::LVL_TICK] = timer0_out;
        state_next.lvl[bir_pkg::LVL_EXP1] =
            exp_s[bir_pkg::LVL_EXP1];
        state_next.lvl[bir_pkg::LVL_CASCADE] =
            second_ctrl_int;
        state_next.lvl[bir_pkg::LVL_SER_TWO] =
            serial_channel_two_irq;
        state_next.lvl[bir_pkg::LVL_SER_ONE] =
            serial_channel_one_irq;
        state_next.lvl[bir_pkg::LVL_FIVE] = pick(
            state_reg.route[bir_pkg::ROUTE_BIT_FIVE],
            exp_s[bir_pkg::LVL_FIVE], mod_a_s);
        state_next.lvl[bir_pkg::LVL_EXP6] =
            exp_s[bir_pkg::LVL_EXP6];
        state_next.lvl[bir_pkg::LVL_EXP7] =
            exp_s[bir_pkg::LVL_EXP7];
        state_next.lvl[bir_pkg::LVL_EXP8] =
            exp_s[bir_pkg::LVL_EXP8];
        state_next.lvl[bir_pkg::LVL_NINE] = pick(
            state_reg.route[bir_pkg::ROUTE_BIT_NINE],
            exp_s[bir_pkg::LVL_NINE], mod_b_s);
        state_next.lvl[bir_pkg::LVL_TMR1] = timer1_out &&
            state_reg.t1_use == bir_pkg::T1_IRQ_LEVEL;
        state_next.lvl[bir_pkg::LVL_TMR2] = timer2_out;
        state_next.lvl[bir_pkg::LVL_DMA] = dma_irq;
        state_next.lvl[bir_pkg::LVL_EXP13] =
            exp_s[bir_pkg::LVL_EXP13];
        // Clock interrupt from the 1/64 s tick or the alarm match when enabled
        rtc_ev = rtc_irq_en && (rtc_tick || rtc_alarm_match);
        state_next.lvl[bir_pkg::LVL_FOURTEEN] = pick(
            state_reg.route[bir_pkg::ROUTE_BIT_FOURTEEN],
            exp_s[bir_pkg::LVL_FOURTEEN], rtc_ev);
        state_next.wake = rtc_alarm_en && rtc_alarm_match;
        // Timer counter 1 alternative uses
        state_next.smi = smreq_s || (timer1_out &&
            state_reg.t1_use == bir_pkg::T1_SYS_MGMT);
        state_next.dma_trig = timer1_out &&
            state_reg.t1_use == bir_pkg::T1_DMA_TRIG;
        state_next.nmi = pfail_s;
        // Merge core and board events, then rank them; a routed level or
        // the cascade raises the maskable class, the registered power-fail
        // the non-maskable one, the registered entry request its own class
        ev = core_events;
        if ((|state_reg.lvl) || second_ctrl_int) begin
            ev = ev | bir_pkg::EV_MASKABLE;
        end
        if (state_reg.nmi) begin
            ev = ev | bir_pkg::EV_NMI;
        end
        if (state_reg.smi) begin
            ev = ev | bir_pkg::EV_SYS_MGMT;
        end
        state_next.grant = rank(ev);
    end

    // Second controller input two takes timer counter 1 when chosen
    // Kept combinational: the second controller samples its own inputs,
    // and an extra stage here would only add a cycle of latency
    always_comb begin
        second_ctrl_levels = '0;
        second_ctrl_levels[bir_pkg::SEC_INPUT_TWO] = timer1_out &&
            state_reg.t1_use == bir_pkg::T1_SEC_TWO;
    end

    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '{route: bir_pkg::ROUTE_RESET,
                           t1_use: bir_pkg::T1_IRQ_LEVEL,
                           cfg_taken: 1'b0, lvl: '0, nmi: 1'b0,
                           smi: 1'b0, dma_trig: 1'b0, wake: 1'b0,
                           grant: bir_pkg::EV_NONE};
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs from flip-flops
    // Every routed output except second_ctrl_levels is a flop and shows no glitches
    assign first_ctrl_levels = state_reg.lvl;
    assign nmi = state_reg.nmi;
    assign system_management_entry = state_reg.smi;
    assign dma_trigger = state_reg.dma_trig;
    assign rtc_wakeup = state_reg.wake;
    assign event_grant = state_reg.grant;
endmodule : bir_router

// >>> test/bir_core_model.sv
// Core-side model: raises exception classes, keeps the last granted event
`timescale 1ns/100ps
module bir_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Class requests from the bench, grant from the router
    input wire logic [9:0] raise,
    input wire bir_pkg::bir_event_t event_grant,
    // Classes presented to the router, last non-empty grant
    output logic [9:0] core_events,
    output logic [9:0] last_grant
);
    // =========================================================
    // Core event register
    // Classes are taken on the edge after the bench asks for them
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            core_events <= '0;
            last_grant <= '0;
        end else begin
            core_events <= raise;
            if (event_grant != bir_pkg::EV_NONE) begin
                last_grant <= event_grant;
            end
        end
    end
endmodule : bir_core_model

// >>> test/bir_router_sva.sv
// Checker of timing relations between router inputs and routed outputs
`timescale 1ns/100ps
module bir_router_sva #(
    parameter int LEVELS = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Same-clock sources
    input wire logic timer0_out,
    input wire logic timer1_out,
    input wire logic timer2_out,
    input wire logic dma_irq,
    input wire logic second_ctrl_int,
    input wire logic serial_channel_one_irq,
    input wire logic serial_channel_two_irq,
    // Pin sources
    input wire logic [LEVELS-1:0] expansion_irq,
    input wire logic module_bus_irq_a,
    input wire logic module_bus_irq_b,
    input wire logic power_fail,
    // Configuration and core classes
    input wire logic [2:0] route_sel,
    input wire logic [1:0] timer1_use,
    input wire logic [9:0] core_events,
    // Outputs
    input wire logic [LEVELS-1:0] first_ctrl_levels,
    input wire logic [LEVELS-1:0] second_ctrl_levels,
    input wire logic nmi,
    input wire bir_pkg::bir_event_t event_grant
);
    // =========================================================
    // Relations, one edge for local sources (none for second input two), three for pins
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_tick; first_ctrl_levels[0] == $past(timer0_out); endproperty
    a_tick: assert property (p_tick)
        else $error("tick level wrong");
    property p_casc; first_ctrl_levels[2] == $past(second_ctrl_int);
    endproperty
    a_casc: assert property (p_casc)
        else $error("cascade level wrong");
    property p_ser; first_ctrl_levels[4:3] == $past({serial_channel_one_irq,
        serial_channel_two_irq}); endproperty
    a_ser: assert property (p_ser)
        else $error("serial levels wrong");
    property p_t2dma; first_ctrl_levels[12:11] == $past({dma_irq, timer2_out});
    endproperty
    a_t2dma: assert property (p_t2dma)
        else $error("level 11/12 wrong");
    property p_t1;
        first_ctrl_levels[10] == $past(timer1_out && timer1_use == 2'h0);
    endproperty
    a_t1: assert property (p_t1)
        else $error("level 10 wrong");
    property p_direct; first_ctrl_levels[1] == $past(expansion_irq[1], 3) &&
        first_ctrl_levels[13] == $past(expansion_irq[13], 3); endproperty
    a_direct: assert property (p_direct)
        else $error("direct line wrong");
    property p_five; first_ctrl_levels[5] == $past(route_sel[0] ?
        module_bus_irq_a : expansion_irq[5], 3); endproperty
    a_five: assert property (p_five)
        else $error("level 5 wrong");
    property p_nine; first_ctrl_levels[9] == $past(route_sel[1] ?
        module_bus_irq_b : expansion_irq[9], 3); endproperty
    a_nine: assert property (p_nine)
        else $error("level 9 wrong");
    property p_nmi; nmi == $past(power_fail, 3); endproperty
    a_nmi: assert property (p_nmi)
        else $error("nmi wrong");
    property p_sec; second_ctrl_levels[2] == (timer1_out && timer1_use == 2'h3);
    endproperty
    a_sec: assert property (p_sec)
        else $error("second input two wrong");
    property p_top; core_events[9] |=> event_grant == bir_pkg::EV_DOUBLE_FAULT;
    endproperty
    a_top: assert property (p_top)
        else $error("double fault lost");
endmodule : bir_router_sva

bind bir_router bir_router_sva #(.LEVELS(LEVELS)) u_sva (.clk(clk),
    .resetn(resetn), .timer0_out(timer0_out), .timer1_out(timer1_out),
    .timer2_out(timer2_out), .dma_irq(dma_irq), .power_fail(power_fail),
    .second_ctrl_int(second_ctrl_int),
    .serial_channel_one_irq(serial_channel_one_irq),
    .serial_channel_two_irq(serial_channel_two_irq),
    .expansion_irq(expansion_irq), .module_bus_irq_a(module_bus_irq_a),
    .module_bus_irq_b(module_bus_irq_b), .route_sel(route_sel),
    .timer1_use(timer1_use), .core_events(core_events), .nmi(nmi),
    .first_ctrl_levels(first_ctrl_levels), .event_grant(event_grant),
    .second_ctrl_levels(second_ctrl_levels));

// >>> test/tb.sv
// Self-checking testbench for board interrupt routing
`timescale 1ns/100ps
module tb;
    // =========================================================
    // Stimulus and observed signals
    logic clk, resetn, t0, t1, t2, s1, s2, dma, rie, rae, rtk, ram;
    logic mba, mbb, pf, smr, nmi, sme, wake, sci, dtrig;
    logic [15:0] exp_irq, lv1, lv2;
    logic [2:0] rsel;
    logic [1:0] use1;
    logic [9:0] raise, cev, lastg;
    bir_pkg::bir_event_t grant;
    int fails = 0;
    int compares = 0;
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    bir_core_model core (.clk(clk), .resetn(resetn), .raise(raise),
        .event_grant(grant), .core_events(cev), .last_grant(lastg));
    bir_router dut (.clk(clk), .resetn(resetn), .timer0_out(t0),
        .timer1_out(t1), .timer2_out(t2), .serial_channel_one_irq(s1),
        .serial_channel_two_irq(s2), .dma_irq(dma), .second_ctrl_int(sci),
        .rtc_irq_en(rie), .rtc_alarm_en(rae), .rtc_tick(rtk),
        .rtc_alarm_match(ram), .expansion_irq(exp_irq),
        .module_bus_irq_a(mba), .module_bus_irq_b(mbb), .power_fail(pf),
        .sys_mgmt_req(smr), .route_sel(rsel), .timer1_use(use1),
        .core_events(cev), .first_ctrl_levels(lv1), .second_ctrl_levels(lv2),
        .nmi(nmi), .system_management_entry(sme), .dma_trigger(dtrig),
        .rtc_wakeup(wake), .event_grant(grant));
    // Compare and count
    task automatic chk(input string nm, input logic [15:0] e, g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt
    task automatic drive_idle();
        {t0, t1, t2, s1, s2, dma, rie, rae, rtk, ram, mba, mbb, pf, smr} <= '0;
        sci <= 1'b0;
        exp_irq <= '0;
        raise <= '0;
    endtask : drive_idle
    task automatic rst(input logic [2:0] r, input logic [1:0] u);
        @(posedge clk);
        drive_idle();
        rsel <= r;
        use1 <= u;
        resetn <= 1'b0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        wt(2);
    endtask : rst
    // =========================================================
    // Scenarios
    task automatic t_local();
        logic [15:0] lvl [7] = '{16'h0001, 16'h0008, 16'h0010, 16'h0400,
            16'h0800, 16'h1000, 16'h0004};
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            {sci, dma, t2, t1, s1, s2, t0} <= 7'h01 << i;
            wt(2);
            chk("levels", lvl[i], lv1);
        end
        @(posedge clk);
        drive_idle();
        $display("t_local done");
    endtask : t_local
    task automatic t_pins(input logic [15:0] e_exp, e_alt);
        @(posedge clk);
        exp_irq <= 16'hffff;
        wt(4);
        chk("expansion levels", e_exp, lv1);
        @(posedge clk);
        {exp_irq, mba, mbb, rie, rtk} <= {16'h0, 4'hf};
        wt(4);
        chk("alternate levels", e_alt, lv1);
        @(posedge clk);
        drive_idle();
        $display("t_pins done");
    endtask : t_pins
    task automatic t_events();
        @(posedge clk);
        pf <= 1'b1;
        wt(5);
        chk("nmi", 16'h1, {15'h0, nmi});
        @(posedge clk);
        smr <= 1'b1;
        wt(5);
        chk("sys entry", 16'h1, {15'h0, sme});
        chk("grant", bir_pkg::EV_SYS_MGMT, grant);
        @(posedge clk);
        drive_idle();
        wt(5);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            raise <= 10'h3ff >> (9 - i);
            wt(3);
            chk("grant", 10'h001 << i, grant);
        end
        chk("last grant", 16'h0200, lastg);
        @(posedge clk);
        drive_idle();
        $display("t_events done");
    endtask : t_events
    task automatic t_misc();
        @(posedge clk);
        {t1, rae, ram} <= 3'h7;
        wt(3);
        chk("second levels", 16'h0004, lv2);
        chk("level 10 idle", 16'h0, lv1);
        chk("wake", 16'h1, {15'h0, wake});
        @(posedge clk);
        drive_idle();
        $display("t_misc done");
    endtask : t_misc
    task automatic t_timer_uses();
        rst(3'h0, 2'h1);
        @(posedge clk);
        t1 <= 1'b1;
        wt(2);
        chk("sys entry t1", 16'h1, {15'h0, sme});
        chk("dma trigger off", 16'h0, {15'h0, dtrig});
        chk("level 10 off", 16'h0, lv1);
        rst(3'h0, 2'h2);
        @(posedge clk);
        t1 <= 1'b1;
        wt(2);
        chk("dma trigger", 16'h1, {15'h0, dtrig});
        chk("sys entry off", 16'h0, {15'h0, sme});
        chk("second levels off", 16'h0, lv2);
        @(posedge clk);
        drive_idle();
        $display("t_timer_uses done");
    endtask : t_timer_uses
    // =========================================================
    // Verdict, main sequence and hang guard
    task automatic give_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict
    initial begin
        resetn = 1'b0;
        {t0, t1, t2, s1, s2, dma, rie, rae, rtk, ram, mba, mbb, pf, smr} = '0;
        {exp_irq, raise, rsel, use1, sci} = '0;
        rst(3'h0, 2'h0);
        t_local();
        t_pins(16'h63e2, 16'h0000);
        t_events();
        rst(3'h7, 2'h3);
        t_pins(16'h21c2, 16'h4220);
        t_misc();
        t_timer_uses();
        give_verdict();
    end
    initial begin
        #100000;
        fails++;
        give_verdict();
    end
endmodule : tb
